// *** include/rsst_params.svh ***
// What this block does
// - sample all four line inputs together and hold their logic states
// - two serial receivers, each fed from an input chosen by the mode
// - two-wire segment mode: first and second inputs are the two ends, decoded apart
// - segment mode: forward line data both ways while each side is decoded
// - combined mode: split bus on first two inputs, tapped bus on third
// - direction flag (1 second-to-first) and forwarded level, each with valid
// - each aux pin: input pull-down/up, static low/high, or a status output
// - aux direction output drives 0 first-to-second, 1 second-to-first
// - aux forwarded-activity output drives 1 while split bus is driven
// - aux channel-activity output drives 1 while that input is driven
// - aux error output pulses one bit period on framing, parity or break
// - per-channel termination switch taken from the wiring settings
// - two-wire segment mode: first segment is source A, second is source B
// - plain two-wire tap decodes only the first input, all traffic
// - four-wire segment: first and second merged into A, third is B
`ifndef RSST_PARAMS_SVH
`define RSST_PARAMS_SVH

`define RSST_CHANNELS     4
`define RSST_AUX_PINS     2
`define RSST_DIV_W        16
`define RSST_DATA_BITS    8
`define RSST_IDLE_LEVEL   1'b1
`define RSST_CH_FIRST     0
`define RSST_CH_SECOND    1
`define RSST_CH_THIRD     2

`endif

// *** include/rsst_pkg.sv ***
package rsst_pkg;

  // connection modes
  typedef enum logic [1:0] {
    MODE_TAP2,
    MODE_SEG2,
    MODE_TAP4,
    MODE_SEG4
  } rsst_mode_t;

  // aux pin settings
  typedef enum logic [3:0] {
    AUX_IN_PULLDOWN,
    AUX_IN_PULLUP,
    AUX_OUT_LOW,
    AUX_OUT_HIGH,
    AUX_OUT_DIR,
    AUX_OUT_FWD_ACT,
    AUX_OUT_ACT_FIRST,
    AUX_OUT_ACT_SECOND,
    AUX_OUT_ACT_THIRD,
    AUX_OUT_ACT_FOURTH,
    AUX_OUT_ERROR
  } rsst_aux_cfg_t;

  typedef enum logic [1:0] {
    DIR_IDLE,
    DIR_FROM_FIRST,
    DIR_FROM_SECOND
  } rsst_dir_state_t;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_PARITY,
    RX_STOP
  } rsst_rx_state_t;

endpackage : rsst_pkg

// *** core/rsst_uart_rx.sv ***
`timescale 1ns/1ps
`include "rsst_params.svh"

module rsst_uart_rx
  import rsst_pkg::*;
#(
  parameter int DATA_BITS = `RSST_DATA_BITS,
  parameter int DIV_W     = `RSST_DIV_W
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  // line and setup
  input  wire logic                 rxEnable,
  input  wire logic                 rxIn,
  input  wire logic [DIV_W-1:0]     bitDiv,
  input  wire logic                 parityEn,
  input  wire logic                 parityOdd,
  // received byte and errors
  output logic      [DATA_BITS-1:0] rxData,
  output logic                      rxValid,
  output logic                      frameErr,
  output logic                      parityErr,
  output logic                      breakErr
);

  if (DATA_BITS < 5 || DATA_BITS > 9 || DIV_W < 2) begin : g_bad_param
    $error("rsst_uart_rx: unsupported parameters");
  end

  rsst_rx_state_t     state_q;
  logic [DIV_W-1:0]   cnt_q;
  logic [3:0]         bitIdx_q;
  logic [DATA_BITS-1:0] shift_q;
  logic               par_q;
  logic               parBad_q;
  logic               cntZero;

  assign cntZero = (cnt_q == '0);

  // ----------------------------------------------------------------
  // frame sampler: mid-bit sampling, start bit re-checked at half bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q   <= RX_IDLE;
      cnt_q     <= '0;
      bitIdx_q  <= 4'h0;
      shift_q   <= '0;
      par_q     <= 1'b0;
      parBad_q  <= 1'b0;
      rxData    <= '0;
      rxValid   <= 1'b0;
      frameErr  <= 1'b0;
      parityErr <= 1'b0;
      breakErr  <= 1'b0;
    end else begin
      rxValid   <= 1'b0;
      frameErr  <= 1'b0;
      parityErr <= 1'b0;
      breakErr  <= 1'b0;
      if (!cntZero) begin
        cnt_q <= cnt_q - 1'b1;
      end
      case (state_q)
        RX_IDLE: begin
          if (rxEnable && !rxIn) begin
            cnt_q   <= bitDiv >> 1;
            state_q <= RX_START;
          end
        end
        RX_START: begin
          if (cntZero) begin
            // a glitch shorter than half a bit is dropped
            state_q  <= rxIn ? RX_IDLE : RX_DATA;
            cnt_q    <= bitDiv - 1'b1;
            bitIdx_q <= 4'h0;
            par_q    <= 1'b0;
          end
        end
        RX_DATA: begin
          if (cntZero) begin
            shift_q  <= {rxIn, shift_q[DATA_BITS-1:1]};
            par_q    <= par_q ^ rxIn;
            cnt_q    <= bitDiv - 1'b1;
            bitIdx_q <= bitIdx_q + 4'h1;
            if (bitIdx_q == 4'(DATA_BITS - 1)) begin
              state_q <= parityEn ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (cntZero) begin
            parBad_q <= (par_q ^ rxIn) != parityOdd;
            cnt_q    <= bitDiv - 1'b1;
            state_q  <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (cntZero) begin
            rxData    <= shift_q;
            rxValid   <= 1'b1;
            frameErr  <= !rxIn;
            breakErr  <= !rxIn && (shift_q == '0);
            parityErr <= parityEn && parBad_q;
            parBad_q  <= 1'b0;
            state_q   <= RX_IDLE;
          end
        end
        default: state_q <= RX_IDLE;
      endcase
    end
  end

endmodule : rsst_uart_rx

// *** core/rsst_frontend.sv ***
`timescale 1ns/1ps
`include "rsst_params.svh"

module rsst_frontend
  import rsst_pkg::*;
#(
  parameter int DIV_W     = `RSST_DIV_W,
  parameter int DATA_BITS = `RSST_DATA_BITS
) (
  // clock and reset
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // line inputs: level and driven (not idle) per channel
  input  wire logic                    lineInputFirst,
  input  wire logic                    lineInputSecond,
  input  wire logic                    lineInputThird,
  input  wire logic                    lineInputFourth,
  input  wire logic [3:0]              lineDriven,
  // forwarding drivers toward the two segments
  output logic                         fwdFirstOut,
  output logic                         fwdFirstOe,
  output logic                         fwdSecondOut,
  output logic                         fwdSecondOe,
  // wiring settings
  input  wire rsst_mode_t              mode,
  input  wire logic [3:0]              termEnable,
  output logic      [3:0]              termOn,
  // receiver setup
  input  wire logic [DIV_W-1:0]        bitDivA,
  input  wire logic [DIV_W-1:0]        bitDivB,
  input  wire logic                    parityEn,
  input  wire logic                    parityOdd,
  // recorded channel states and indicators
  output logic      [3:0]              chanLevel,
  output logic      [3:0]              chanActive,
  output logic                         busDir,
  output logic                         busDirValid,
  output logic                         busSig,
  output logic                         busSigValid,
  // decoded data, source A and source B
  output logic      [DATA_BITS-1:0]    dataA,
  output logic                         validA,
  output logic      [DATA_BITS-1:0]    dataB,
  output logic                         validB,
  output logic                         errA,
  output logic                         errB,
  // aux pins
  input  wire rsst_aux_cfg_t           auxCfg [`RSST_AUX_PINS],
  input  wire logic [`RSST_AUX_PINS-1:0] auxIn,
  output logic      [`RSST_AUX_PINS-1:0] auxOut,
  output logic      [`RSST_AUX_PINS-1:0] auxOe,
  output logic      [`RSST_AUX_PINS-1:0] auxPullUp,
  output logic      [`RSST_AUX_PINS-1:0] auxPullDown,
  output logic      [`RSST_AUX_PINS-1:0] auxLevel
);

  if (DIV_W < 2 || DATA_BITS < 5 || DATA_BITS > 9) begin : g_bad_param
    $error("rsst_frontend: unsupported parameters");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  rsst_dir_state_t  dirState_q;
  logic             segMode;
  logic             rxInA;
  logic             rxInB;
  logic             rxEnB;
  logic             merged;
  logic             fErrA, pErrA, bErrA;
  logic             fErrB, pErrB, bErrB;
  logic [DIV_W-1:0] errCnt_q;
  logic             errActive_q;

  assign segMode = (mode == MODE_SEG2) || (mode == MODE_SEG4);

  // ----------------------------------------------------------------
  // input sampling and termination
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      chanLevel  <= {4{`RSST_IDLE_LEVEL}};
      chanActive <= 4'h0;
    end else begin
      // all four taken on the same edge
      chanLevel  <= {lineInputFourth, lineInputThird,
                     lineInputSecond, lineInputFirst};
      chanActive <= lineDriven;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      termOn <= 4'h0;
    end else begin
      termOn <= termEnable;
    end
  end

  // ----------------------------------------------------------------
  // direction tracking between the two segments
  // ----------------------------------------------------------------
  // the target segment sees our own drive, so only the source decides
  // when the split bus has gone idle again
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      dirState_q <= DIR_IDLE;
    end else begin
      case (dirState_q)
        DIR_IDLE: begin
          if (segMode && chanActive[`RSST_CH_FIRST]) begin
            dirState_q <= DIR_FROM_FIRST;
          end else if (segMode && chanActive[`RSST_CH_SECOND]) begin
            dirState_q <= DIR_FROM_SECOND;
          end
        end
        DIR_FROM_FIRST: begin
          if (!segMode || !chanActive[`RSST_CH_FIRST]) begin
            dirState_q <= DIR_IDLE;
          end
        end
        DIR_FROM_SECOND: begin
          if (!segMode || !chanActive[`RSST_CH_SECOND]) begin
            dirState_q <= DIR_IDLE;
          end
        end
        default: dirState_q <= DIR_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // forwarding drivers and tri-state indicators
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fwdFirstOut  <= `RSST_IDLE_LEVEL;
      fwdFirstOe   <= 1'b0;
      fwdSecondOut <= `RSST_IDLE_LEVEL;
      fwdSecondOe  <= 1'b0;
      busDir       <= 1'b0;
      busDirValid  <= 1'b0;
      busSig       <= `RSST_IDLE_LEVEL;
      busSigValid  <= 1'b0;
    end else begin
      fwdSecondOut <= chanLevel[`RSST_CH_FIRST];
      fwdFirstOut  <= chanLevel[`RSST_CH_SECOND];
      fwdSecondOe  <= (dirState_q == DIR_FROM_FIRST);
      fwdFirstOe   <= (dirState_q == DIR_FROM_SECOND);
      busDir       <= (dirState_q == DIR_FROM_SECOND);
      busDirValid  <= (dirState_q != DIR_IDLE);
      busSig       <= merged;
      busSigValid  <= (dirState_q != DIR_IDLE);
    end
  end

  // ----------------------------------------------------------------
  // receiver routing
  // ----------------------------------------------------------------
  always_comb begin
    case (dirState_q)
      DIR_FROM_FIRST:  merged = chanLevel[`RSST_CH_FIRST];
      DIR_FROM_SECOND: merged = chanLevel[`RSST_CH_SECOND];
      default:         merged = `RSST_IDLE_LEVEL;
    endcase
  end

  always_comb begin
    rxInA = chanLevel[`RSST_CH_FIRST];
    rxInB = chanLevel[`RSST_CH_SECOND];
    rxEnB = 1'b1;
    case (mode)
      MODE_TAP2: rxEnB = 1'b0;
      MODE_SEG2: begin
        // our own echo on the far segment is not that segment's data
        if (dirState_q == DIR_FROM_SECOND) rxInA = `RSST_IDLE_LEVEL;
        if (dirState_q == DIR_FROM_FIRST)  rxInB = `RSST_IDLE_LEVEL;
      end
      MODE_SEG4: begin
        rxInA = merged;
        rxInB = chanLevel[`RSST_CH_THIRD];
      end
      default: rxEnB = 1'b1;
    endcase
  end

  rsst_uart_rx #(.DATA_BITS(DATA_BITS), .DIV_W(DIV_W)) u_rxA (
    .clk       (clk),
    .reset_n   (reset_n),
    .rxEnable  (1'b1),
    .rxIn      (rxInA),
    .bitDiv    (bitDivA),
    .parityEn  (parityEn),
    .parityOdd (parityOdd),
    .rxData    (dataA),
    .rxValid   (validA),
    .frameErr  (fErrA),
    .parityErr (pErrA),
    .breakErr  (bErrA)
  );

  rsst_uart_rx #(.DATA_BITS(DATA_BITS), .DIV_W(DIV_W)) u_rxB (
    .clk       (clk),
    .reset_n   (reset_n),
    .rxEnable  (rxEnB),
    .rxIn      (rxInB),
    .bitDiv    (bitDivB),
    .parityEn  (parityEn),
    .parityOdd (parityOdd),
    .rxData    (dataB),
    .rxValid   (validB),
    .frameErr  (fErrB),
    .parityErr (pErrB),
    .breakErr  (bErrB)
  );

  assign errA = fErrA | pErrA | bErrA;
  assign errB = fErrB | pErrB | bErrB;

  // ----------------------------------------------------------------
  // error pulse stretcher, one bit period of the erring receiver
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      errCnt_q    <= '0;
      errActive_q <= 1'b0;
    end else if (errA || errB) begin
      errCnt_q    <= (errA ? bitDivA : bitDivB) - 1'b1;
      errActive_q <= 1'b1;
    end else if (errCnt_q != '0) begin
      errCnt_q    <= errCnt_q - 1'b1;
    end else begin
      errActive_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // aux pins
  // ----------------------------------------------------------------
  function automatic logic auxValue(input rsst_aux_cfg_t cfg);
    case (cfg)
      AUX_OUT_HIGH:       auxValue = 1'b1;
      AUX_OUT_DIR:        auxValue = busDir;
      AUX_OUT_FWD_ACT:    auxValue = busDirValid;
      AUX_OUT_ACT_FIRST:  auxValue = chanActive[0];
      AUX_OUT_ACT_SECOND: auxValue = chanActive[1];
      AUX_OUT_ACT_THIRD:  auxValue = chanActive[2];
      AUX_OUT_ACT_FOURTH: auxValue = chanActive[3];
      AUX_OUT_ERROR:      auxValue = errActive_q;
      default:            auxValue = 1'b0;
    endcase
  endfunction : auxValue

  for (genvar i = 0; i < `RSST_AUX_PINS; i++) begin : g_aux
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        auxOut[i]      <= 1'b0;
        auxOe[i]       <= 1'b0;
        auxPullUp[i]   <= 1'b0;
        auxPullDown[i] <= 1'b1;
        auxLevel[i]    <= 1'b0;
      end else begin
        // pins default to inputs so nothing fights an external driver
        auxOut[i]      <= auxValue(auxCfg[i]);
        auxOe[i]       <= (auxCfg[i] != AUX_IN_PULLDOWN) &&
                          (auxCfg[i] != AUX_IN_PULLUP);
        auxPullUp[i]   <= (auxCfg[i] == AUX_IN_PULLUP);
        auxPullDown[i] <= (auxCfg[i] == AUX_IN_PULLDOWN);
        auxLevel[i]    <= auxIn[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_SAMPLE: assert property (
    ##1 chanLevel == $past({lineInputFourth, lineInputThird,
                            lineInputSecond, lineInputFirst}))
    else $error("channel levels not sampled together");

  AST_SEG2_ROUTE: assert property (
    mode == MODE_SEG2
      |-> rxInA == (chanLevel[0] || dirState_q == DIR_FROM_SECOND) &&
          rxInB == (chanLevel[1] || dirState_q == DIR_FROM_FIRST))
    else $error("segment receivers wrongly routed");

  AST_FORWARD: assert property (
    dirState_q == DIR_FROM_FIRST |=> fwdSecondOe && !fwdFirstOe &&
      fwdSecondOut == $past(chanLevel[0]))
    else $error("first segment not forwarded to second");

  AST_SEG4_ROUTE: assert property (
    mode == MODE_SEG4 |-> rxInB == chanLevel[2] && rxInA == merged)
    else $error("combined mode routing wrong");

  AST_DIR_MARK: assert property (
    dirState_q == DIR_FROM_SECOND |=> busDirValid && busDir && busSigValid)
    else $error("direction mark missing");

  AST_RELEASE: assert property (
    dirState_q == DIR_IDLE |=> !fwdFirstOe && !fwdSecondOe && !busDirValid)
    else $error("forwarding driver not released");

  AST_HOLD: assert property (
    dirState_q == DIR_FROM_FIRST && segMode && chanActive[0]
      |=> dirState_q == DIR_FROM_FIRST)
    else $error("direction dropped while source busy");

  AST_ERR_PULSE: assert property (
    errA && !errB && bitDivA == 16'h0008 && $stable(bitDivA)
      |=> errActive_q [*8] ##1 (!errActive_q || $past(errA || errB)))
    else $error("error pulse shorter than a bit");

  AST_TAP2: assert property (
    mode == MODE_TAP2 |-> !rxEnB && rxInA == chanLevel[0])
    else $error("second receiver active in plain tap");

  AST_AUX_DIR: assert property (
    auxCfg[0] == AUX_OUT_DIR |=> auxOe[0] && auxOut[0] == $past(busDir))
    else $error("aux direction output wrong");

endmodule : rsst_frontend

// *** sim/rsst_seg_model.sv ***
`timescale 1ns/1ps

module rsst_seg_model (
  // remote devices, as commanded by the bench
  input  wire logic [3:0] devDrive,
  input  wire logic [3:0] devLevel,
  // forwarding drivers of the block
  input  wire logic       fwdFirstOut,
  input  wire logic       fwdFirstOe,
  input  wire logic       fwdSecondOut,
  input  wire logic       fwdSecondOe,
  // resolved lines
  output logic      [3:0] lineLevel,
  output logic      [3:0] lineDriven
);
  // ----------------------------------------
  // line resolution
  // ----------------------------------------
  // idle bias pulls an undriven pair to mark; remote device wins contention
  // activity only reflects remote devices, so our own drive cannot latch it
  always_comb begin
    lineDriven = devDrive;
    for (int i = 0; i < 4; i++) begin
      lineLevel[i] = devDrive[i] ? devLevel[i] : 1'b1;
    end
    if (!devDrive[0] && fwdFirstOe) begin
      lineLevel[0] = fwdFirstOut;
    end
    if (!devDrive[1] && fwdSecondOe) begin
      lineLevel[1] = fwdSecondOut;
    end
  end
endmodule : rsst_seg_model

// *** sim/rsst_frontend_test.sv ***
`timescale 1ns/1ps
`include "rsst_params.svh"

module rsst_frontend_test;
  import rsst_pkg::*;
  localparam int DIV  = 8;
  localparam int DIVB = 12;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic                       clk         = 1'b0;
  logic                       reset_n     = 1'b0;
  logic [3:0]                 devDrive    = 4'h0;
  logic [3:0]                 devLevel    = 4'hf;
  logic [3:0]                 lineLevel;
  logic [3:0]                 lineDriven;
  logic                       fwdFirstOut, fwdFirstOe;
  logic                       fwdSecondOut, fwdSecondOe;
  rsst_mode_t                 mode        = MODE_TAP2;
  logic [3:0]                 termEnable  = 4'h0;
  logic [3:0]                 termOn, chanLevel, chanActive;
  logic [15:0]                bitDivA     = 16'(DIV);
  logic [15:0]                bitDivB     = 16'(DIVB);
  logic                       parityEn    = 1'b0;
  logic                       parityOdd   = 1'b0;
  logic                       busDir, busDirValid, busSig, busSigValid;
  logic [7:0]                 dataA, dataB;
  logic                       validA, validB, errA, errB;
  rsst_aux_cfg_t              auxCfg [`RSST_AUX_PINS];
  logic [1:0]                 auxIn       = 2'h0;
  logic [1:0]                 auxOut, auxOe, auxPullUp, auxPullDown, auxLevel;
  logic [1:0]                 quiet       = 2'h3;
  logic [31:0]                seed        = 32'h54;
  logic [7:0]                 qA [$];
  logic [7:0]                 qB [$];
  int                         error_cnt   = 0;
  int                         checked     = 0;

  always #12.5 clk = ~clk;

  rsst_seg_model i_rsst_seg_model (
    .devDrive(devDrive), .devLevel(devLevel),
    .fwdFirstOut(fwdFirstOut), .fwdFirstOe(fwdFirstOe),
    .fwdSecondOut(fwdSecondOut), .fwdSecondOe(fwdSecondOe),
    .lineLevel(lineLevel), .lineDriven(lineDriven)
  );

  rsst_frontend i_rsst_frontend (
    .clk(clk), .reset_n(reset_n),
    .lineInputFirst(lineLevel[0]), .lineInputSecond(lineLevel[1]),
    .lineInputThird(lineLevel[2]), .lineInputFourth(lineLevel[3]),
    .lineDriven(lineDriven),
    .fwdFirstOut(fwdFirstOut), .fwdFirstOe(fwdFirstOe),
    .fwdSecondOut(fwdSecondOut), .fwdSecondOe(fwdSecondOe),
    .mode(mode), .termEnable(termEnable), .termOn(termOn),
    .bitDivA(bitDivA), .bitDivB(bitDivB),
    .parityEn(parityEn), .parityOdd(parityOdd),
    .chanLevel(chanLevel), .chanActive(chanActive),
    .busDir(busDir), .busDirValid(busDirValid),
    .busSig(busSig), .busSigValid(busSigValid),
    .dataA(dataA), .validA(validA), .dataB(dataB), .validB(validB),
    .errA(errA), .errB(errB),
    .auxCfg(auxCfg), .auxIn(auxIn), .auxOut(auxOut), .auxOe(auxOe),
    .auxPullUp(auxPullUp), .auxPullDown(auxPullDown), .auxLevel(auxLevel)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick

  task automatic report_and_stop();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  // one frame, lsb first; flip spoils the parity bit
  task automatic send(input int ch, input logic [7:0] d, input logic stopBit,
                      input int div, input logic flip);
    devDrive[ch] = 1'b1;
    devLevel[ch] = 1'b1;
    tick(div);
    devLevel[ch] = 1'b0;
    tick(div);
    for (int b = 0; b < 8; b++) begin
      devLevel[ch] = d[b];
      tick(div);
    end
    if (parityEn) begin
      devLevel[ch] = ^d ^ parityOdd ^ flip;
      tick(div);
    end
    devLevel[ch] = stopBit;
    tick(div);
    devLevel[ch] = 1'b1;
    tick(div);
    devDrive[ch] = 1'b0;
  endtask : send

  // rx: 0 source A, 1 source B, 2 nothing expected
  task automatic run_byte(input rsst_mode_t m, input int ch, input int rx,
                          input logic [1:0] q);
    logic [7:0] d;
    mode = m;
    quiet = q;
    d = 8'(rnd());
    tick(4);
    if (rx == 0) qA.push_back(d);
    if (rx == 1) qB.push_back(d);
    send(ch, d, 1'b1, (rx == 1 || ch > 0 && m != MODE_SEG4) ? DIVB : DIV, 1'b0);
    tick(3 * DIVB);
    check(8'(qA.size() + qB.size()), 8'h00);
  endtask : run_byte

  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(posedge clk) begin
    if (validA && !errA && !quiet[0]) begin
      if (qA.size() == 0) begin
        error_cnt++;
        $display("[ERR] %0t unexpected byte on A", $time);
      end else check(dataA, qA.pop_front());
    end
    if (validB && !errB && !quiet[1]) begin
      if (qB.size() == 0) begin
        error_cnt++;
        $display("[ERR] %0t unexpected byte on B", $time);
      end else check(dataB, qB.pop_front());
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    report_and_stop();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] r;
    int          cnt, cntA, cntB;
    auxCfg[0] = AUX_IN_PULLDOWN;
    auxCfg[1] = AUX_IN_PULLDOWN;
    tick(11);
    check({4'h0, termOn}, 8'h00);
    check({4'h0, chanLevel}, 8'h0f);
    check({4'h0, fwdFirstOe, fwdSecondOe, busDirValid, busSigValid}, 8'h00);
    tick(1);
    reset_n = 1'b1;
    mode = MODE_TAP4;
    auxCfg[1] = AUX_OUT_HIGH;
    for (int i = 0; i < 8; i++) begin
      r = rnd();
      devDrive = r[3:0];
      devLevel = r[7:4];
      termEnable = r[11:8];
      auxCfg[0] = rsst_aux_cfg_t'(4'(AUX_OUT_ACT_FIRST) + 4'(i % 4));
      auxCfg[1] = i[0] ? AUX_OUT_LOW : AUX_OUT_HIGH;
      tick(3);
      check({4'h0, chanActive}, {4'h0, r[3:0]});
      check({4'h0, chanLevel}, {4'h0, r[7:4] | ~r[3:0]});
      check({4'h0, termOn}, {4'h0, r[11:8]});
      check({6'h0, auxOe[0], auxOut[0]}, {6'h0, 1'b1, r[i % 4]});
      check({6'h0, auxOe[1], auxOut[1]}, {6'h0, 1'b1, ~i[0]});
    end
    devDrive = 4'h0;
    devLevel = 4'hf;
    auxCfg[0] = AUX_IN_PULLDOWN;
    auxCfg[1] = AUX_IN_PULLUP;
    auxIn = 2'(rnd());
    tick(3);
    check({auxOe, auxPullUp, auxPullDown, auxLevel}, {6'h09, auxIn});
    // segment forwarding, both directions; a held low looks like a frame
    mode = MODE_SEG2;
    auxCfg[0] = AUX_OUT_DIR;
    auxCfg[1] = AUX_OUT_FWD_ACT;
    for (int s = 0; s < 2; s++) begin
      devDrive[s] = 1'b1;
      devLevel[s] = 1'b0;
      tick(4);
      devDrive[1 - s] = 1'b1;
      tick(4);
      check({busDirValid, busDir, fwdFirstOe, fwdSecondOe, busSigValid,
             busSig, auxOut}, s ? 8'heb : 8'h9a);
      check({7'h0, s ? fwdFirstOut : fwdSecondOut}, 8'h00);
      devLevel[s] = 1'b1;
      tick(4);
      check({6'h0, s ? fwdFirstOut : fwdSecondOut, busSig}, 8'h03);
      devDrive = 4'h0;
      tick(4);
      check({4'h0, busDirValid, busSigValid, fwdFirstOe, fwdSecondOe},
            8'h00);
      check({6'h0, auxOut[1], auxOe[1]}, 8'h01);
    end
    tick(15 * DIVB);
    parityEn = 1'b1;
    r = rnd();
    parityOdd = r[0];
    run_byte(MODE_TAP2, 0, 0, 2'h0);
    run_byte(MODE_TAP2, 1, 2, 2'h0);
    run_byte(MODE_SEG2, 0, 0, 2'h0);
    run_byte(MODE_SEG2, 1, 1, 2'h0);
    run_byte(MODE_TAP4, 0, 0, 2'h0);
    run_byte(MODE_TAP4, 1, 1, 2'h0);
    run_byte(MODE_SEG4, 0, 0, 2'h0);
    run_byte(MODE_SEG4, 1, 0, 2'h0);
    run_byte(MODE_SEG4, 2, 1, 2'h0);
    // break, framing and parity faults each give one bit-long pulse
    mode = MODE_TAP4;
    quiet = 2'h0;
    auxCfg[0] = AUX_OUT_ERROR;
    tick(4);
    for (int k = 0; k < 3; k++) begin
      cnt = 0;
      cntA = 0;
      cntB = 0;
      fork
        send(k % 2, k == 1 ? 8'h5a : 8'h00, k == 2,
             k == 1 ? DIVB : DIV, k == 2);
        repeat (14 * DIVB) begin
          @(posedge clk);
          cnt += (auxOut[0] === 1'b1);
          cntA += (errA === 1'b1);
          cntB += (errB === 1'b1);
        end
      join
      check(8'(cnt), k == 1 ? 8'(DIVB) : 8'(DIV));
      check({4'(cntA), 4'(cntB)}, k == 1 ? 8'h01 : 8'h10);
    end
    report_and_stop();
  end
endmodule : rsst_frontend_test
